// *** design/card_ctl_pkg.sv ***
package card_ctl_pkg;

  // clock rate of clk_sys_in
  localparam int CLK_MHZ     = 200;

  // shortest reset pulse that starts a card reset, in ns
  localparam int RST_MIN_NS  = 10000;
  // least time, rounded up to whole cycles
  localparam int RST_MIN_CYC = (RST_MIN_NS * CLK_MHZ + 999) / 1000;

  // card initialization time after reset release, in ns
  localparam int INIT_NS     = 2000000;
  // longest time, rounded down to whole cycles
  localparam int INIT_CYC    = (INIT_NS * CLK_MHZ) / 1000;

  // channels per circuit card and number of cards
  localparam int CH_PER_CARD = 8;
  localparam int NUM_CARDS   = 2;

  // counter widths
  localparam int LO_W        = 16;
  localparam int CNT_W       = 24;

  // reset values
  localparam logic PIN_IDLE_LVL   = 1'b1;
  localparam logic SQ_DIS_RST     = 1'b0;
  localparam logic PEND_RST       = 1'b1;

  // level that an open-drain pin shows while driven
  localparam logic DRIVE_LOW_LVL  = 1'b0;

  // card sequencing states
  typedef enum logic [1:0] {
    CARD_RUN,
    CARD_HOLD,
    CARD_INIT
  } card_state_t;

endpackage

// *** design/card_ctl_unit.sv ***
`timescale 1ns/100ps
module card_ctl_unit
#(
  parameter int RST_MIN_CYC = card_ctl_pkg::RST_MIN_CYC,
  parameter int INIT_CYC    = card_ctl_pkg::INIT_CYC
)
(
  // clock, enable, reset
  input  wire logic clk_sys_in,
  input  wire logic clk_en_in,
  input  wire logic nrst_in,
  // card reset pin
  input  wire logic card_reset_n_in,
  // management side
  input  wire logic np_read_in,
  input  wire logic flag_read_in,
  input  wire logic event_in,
  // card status
  output logic      card_irq_n_out,
  output logic      card_irq_oe_out,
  output logic      init_pending_flag_out,
  output logic      in_reset_out
);

  localparam int LO_W  = card_ctl_pkg::LO_W;
  localparam int CNT_W = card_ctl_pkg::CNT_W;

  // refuse counts the counters cannot hold
  if (RST_MIN_CYC < 1 || RST_MIN_CYC >= 2**LO_W) begin : g_bad_rst
    $error("reset pulse count out of range");
  end
  if (INIT_CYC < 1 || INIT_CYC >= 2**CNT_W) begin : g_bad_init
    $error("init count out of range");
  end

  localparam logic [LO_W-1:0]  LO_MAX    = LO_W'(RST_MIN_CYC);
  localparam logic [CNT_W-1:0] INIT_LAST = CNT_W'(INIT_CYC - 1);

  logic                      s1_r;          // first sync stage
  logic                      s2_r;          // second sync stage
  logic                      s3_r;          // third sync stage
  logic                      lvl_r;         // filtered pin level
  logic [LO_W-1:0]           lo_cnt_r;      // cycles pin stayed low
  logic [CNT_W-1:0]          init_cnt_r;    // init interval counter
  card_ctl_pkg::card_state_t state_r;       // sequencing state
  card_ctl_pkg::card_state_t state_nxt;
  logic                      done_p;        // init finished this cycle
  logic                      done_irq_r;    // completion irq pending
  logic                      done_irq_nxt;
  logic                      evt_irq_r;     // fault or status irq pending
  logic                      evt_irq_nxt;
  logic                      np_seen_r;     // pending bit read as zero
  logic                      flag_seen_r;   // flag field read
  logic                      irq_oe_r;
  logic                      irq_lvl_r;
  logic                      pend_r;
  logic                      inrst_r;

  // three-stage pin sync, level taken once stages two and three agree
  always_ff @(posedge clk_sys_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      s1_r  <= card_ctl_pkg::PIN_IDLE_LVL;
      s2_r  <= card_ctl_pkg::PIN_IDLE_LVL;
      s3_r  <= card_ctl_pkg::PIN_IDLE_LVL;
      lvl_r <= card_ctl_pkg::PIN_IDLE_LVL;
    end
    else if (clk_en_in)
    begin
      s1_r <= card_reset_n_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r)
        lvl_r <= s3_r;
    end
  end

  // low-time counter, saturates at the minimum pulse
  always_ff @(posedge clk_sys_in or negedge nrst_in)
  begin
    if (!nrst_in)
      lo_cnt_r <= '0;
    else if (clk_en_in)
    begin
      if (lvl_r)
        lo_cnt_r <= '0;
      else if (lo_cnt_r != LO_MAX)
        lo_cnt_r <= lo_cnt_r + 1'b1;
    end
  end

  // sequencing: run, held in reset, initializing
  always_comb
  begin
    state_nxt = state_r;
    done_p    = 1'b0;
    case (state_r)
      card_ctl_pkg::CARD_RUN:
        if (lo_cnt_r == LO_MAX)
          state_nxt = card_ctl_pkg::CARD_HOLD; // RULE1
      card_ctl_pkg::CARD_HOLD:
        if (lvl_r)
          state_nxt = card_ctl_pkg::CARD_INIT; // RULE2
      card_ctl_pkg::CARD_INIT:
        if (lo_cnt_r == LO_MAX)
          state_nxt = card_ctl_pkg::CARD_HOLD;
        else if (init_cnt_r == INIT_LAST)
        begin
          state_nxt = card_ctl_pkg::CARD_RUN;
          done_p    = 1'b1;
        end
      default:
        state_nxt = card_ctl_pkg::CARD_HOLD;
    endcase
  end

  // power-up enters init directly so completion is posted unasked
  always_ff @(posedge clk_sys_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      state_r    <= card_ctl_pkg::CARD_INIT; // RULE5
      init_cnt_r <= '0;
    end
    else if (clk_en_in)
    begin
      state_r <= state_nxt;
      if (state_r == card_ctl_pkg::CARD_INIT && state_nxt == card_ctl_pkg::CARD_INIT)
        init_cnt_r <= init_cnt_r + 1'b1;
      else
        init_cnt_r <= '0;
    end
  end

  // irq sources; a new event beats a clear in the same cycle
  always_comb
  begin
    done_irq_nxt = done_irq_r;
    if (done_irq_r && np_seen_r && flag_seen_r)
      done_irq_nxt = 1'b0; // RULE9
    if (state_nxt != card_ctl_pkg::CARD_RUN)
      done_irq_nxt = 1'b0;
    if (done_p)
      done_irq_nxt = 1'b1; // RULE4
    evt_irq_nxt = evt_irq_r;
    if (flag_read_in)
      evt_irq_nxt = 1'b0;
    if (state_nxt != card_ctl_pkg::CARD_RUN)
      evt_irq_nxt = 1'b0;
    if (event_in && state_r == card_ctl_pkg::CARD_RUN)
      evt_irq_nxt = 1'b1; // RULE7
  end

  // irq state and the host reads that release the completion irq
  always_ff @(posedge clk_sys_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      done_irq_r  <= 1'b0;
      evt_irq_r   <= 1'b0;
      np_seen_r   <= 1'b0;
      flag_seen_r <= 1'b0;
    end
    else if (clk_en_in)
    begin
      done_irq_r <= done_irq_nxt;
      evt_irq_r  <= evt_irq_nxt;
      if (!done_irq_nxt || done_p)
      begin
        np_seen_r   <= 1'b0;
        flag_seen_r <= 1'b0;
      end
      else
      begin
        if (np_read_in)
          np_seen_r <= 1'b1; // RULE9
        if (flag_read_in)
          flag_seen_r <= 1'b1; // RULE9
      end
    end
  end

  // registered outputs; irq stays released while init is pending
  always_ff @(posedge clk_sys_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      irq_oe_r  <= 1'b0;
      irq_lvl_r <= card_ctl_pkg::DRIVE_LOW_LVL;
      pend_r    <= card_ctl_pkg::PEND_RST;
      inrst_r   <= 1'b0;
    end
    else if (clk_en_in)
    begin
      irq_oe_r <= (done_irq_nxt || evt_irq_nxt) &&
                  state_nxt == card_ctl_pkg::CARD_RUN; // RULE17
      pend_r   <= state_nxt != card_ctl_pkg::CARD_RUN; // RULE3
      irq_lvl_r <= card_ctl_pkg::DRIVE_LOW_LVL; // RULE7
      inrst_r  <= state_nxt == card_ctl_pkg::CARD_HOLD;
    end
  end

  assign card_irq_n_out        = irq_lvl_r;
  assign card_irq_oe_out       = irq_oe_r;
  assign init_pending_flag_out = pend_r;
  assign in_reset_out          = inrst_r;

  // full low pulse takes the card into reset
  a_reset_taken: assert property (@(posedge clk_sys_in) disable iff (!nrst_in) // RULE1
    clk_en_in && state_r == card_ctl_pkg::CARD_RUN && lo_cnt_r == LO_MAX
    |=> inrst_r && pend_r && !irq_oe_r)
    else $error("long reset pulse not taken");

  // init timing starts at the release edge
  a_init_from_rise: assert property (@(posedge clk_sys_in) disable iff (!nrst_in) // RULE2
    clk_en_in && state_r == card_ctl_pkg::CARD_HOLD && lvl_r
    |=> state_r == card_ctl_pkg::CARD_INIT && init_cnt_r == '0)
    else $error("init not started on release");

  // completion drives irq with pending cleared
  a_done_irq: assert property (@(posedge clk_sys_in) disable iff (!nrst_in) // RULE4
    clk_en_in && done_p |=> irq_oe_r && !pend_r)
    else $error("completion irq missing");

  // irq never driven while init is pending
  a_irq_quiet_init: assert property (@(posedge clk_sys_in) disable iff (!nrst_in) // RULE17
    pend_r |-> !irq_oe_r)
    else $error("irq driven during init");

  // completion irq held until both reads
  a_hold_until_read: assert property (@(posedge clk_sys_in) disable iff (!nrst_in) // RULE9
    clk_en_in && done_irq_r && !(np_seen_r && flag_seen_r) && lo_cnt_r != LO_MAX
    |=> done_irq_r)
    else $error("irq released before reads");

endmodule // card_ctl_unit

// *** design/module_card_reset_irq_squelch.sv ***
// Function
// RULE1: long reset pulse resets card to defaults
// RULE2: init interval timed from reset release
// RULE3: host ignores status until completion
// RULE4: completion drives irq, pending bit cleared
// RULE5: power-up posts completion irq unasked
// RULE6: presence pulled low in module, host pulls up
// RULE7: open-drain irq flags fault or status
// RULE8: host reads status to find irq source
// RULE9: irq released after pending and flag reads
// RULE10: loss of signal squelches receive output
// RULE11: squelch keeps impedance, swing below limit
// RULE12: receive squelch on by default, disableable
// RULE13: transmit input loss squelches, sets flag
// RULE14: transmit squelch on by default, disableable
// RULE15: disable for average power, else squelch
// RULE16: per-card reset and irq, one presence
// RULE17: pending held and irq released during init
`timescale 1ns/100ps
module module_card_reset_irq_squelch
#(
  parameter int   CH_PER_CARD = card_ctl_pkg::CH_PER_CARD,
  parameter bit   TX_SQ_IMPL  = 1'b1,
  parameter int   RST_MIN_CYC = card_ctl_pkg::RST_MIN_CYC,
  parameter int   INIT_CYC    = card_ctl_pkg::INIT_CYC
)
(
  // clock, enable, reset
  input  wire logic                      clk_sys_in,
  input  wire logic                      clk_en_in,
  input  wire logic                      nrst_in,
  // card reset pins
  input  wire logic                      lower_card_reset_n_in,
  input  wire logic                      upper_card_reset_n_in,
  // card irq pins, open drain
  output logic                           lower_card_irq_n_out,
  output logic                           lower_card_irq_oe_out,
  output logic                           upper_card_irq_n_out,
  output logic                           upper_card_irq_oe_out,
  // presence pin
  output logic                           module_present_n_out,
  output logic                           module_present_oe_out,
  // management side, index 0 lower card, 1 upper card
  input  wire logic [1:0]                np_read_in,
  input  wire logic [1:0]                flag_read_in,
  input  wire logic [1:0]                card_fault_in,
  input  wire logic [1:0]                cfg_we_in,
  input  wire logic [CH_PER_CARD-1:0]    cfg_rx_sq_dis_in,
  input  wire logic [CH_PER_CARD-1:0]    cfg_tx_sq_dis_in,
  input  wire logic                      tx_off_avg_power_in,
  // status to management
  output logic [1:0]                     init_pending_flag_out,
  output logic [2*CH_PER_CARD-1:0]       tx_input_loss_flag_out,
  // line detectors
  input  wire logic [2*CH_PER_CARD-1:0]  rx_los_in,
  input  wire logic [2*CH_PER_CARD-1:0]  tx_los_in,
  // line controls
  output logic [2*CH_PER_CARD-1:0]       rx_squelch_out,
  output logic [2*CH_PER_CARD-1:0]       tx_squelch_out,
  output logic [2*CH_PER_CARD-1:0]       tx_disable_out
);

  localparam int NCH = 2 * CH_PER_CARD;

  // refuse a channel count the layout cannot serve
  if (CH_PER_CARD < 1 || CH_PER_CARD > 64) begin : g_bad_ch
    $error("channels per card out of range");
  end

  // spread one bit per card over that card's channels
  function automatic logic [NCH-1:0] per_card(input logic [1:0] b);
    per_card = {{CH_PER_CARD{b[1]}}, {CH_PER_CARD{b[0]}}};
  endfunction

  // take a bit once second and third sync stages agree
  function automatic logic [NCH-1:0] agree(input logic [NCH-1:0] s2,
                                           input logic [NCH-1:0] s3,
                                           input logic [NCH-1:0] cur);
    agree = (s2 & s3) | (cur & (s2 | s3));
  endfunction

  logic [1:0]     irq_n;          // card irq levels
  logic [1:0]     irq_oe;         // card irq enables
  logic [1:0]     pend;           // card init pending
  logic [1:0]     in_reset;       // card held in reset
  logic [1:0]     card_evt;       // status events per card
  logic [NCH-1:0] rx_s1_r;        // receive loss sync stages
  logic [NCH-1:0] rx_s2_r;
  logic [NCH-1:0] rx_s3_r;
  logic [NCH-1:0] rx_los_r;       // filtered receive loss
  logic [NCH-1:0] tx_s1_r;        // transmit input loss sync stages
  logic [NCH-1:0] tx_s2_r;
  logic [NCH-1:0] tx_s3_r;
  logic [NCH-1:0] tx_los_r;       // filtered transmit input loss
  logic [NCH-1:0] rx_dis_r;       // receive squelch disable settings
  logic [NCH-1:0] tx_dis_r;       // transmit squelch disable settings
  logic [NCH-1:0] flag_r;         // transmit input-loss flags
  logic [NCH-1:0] flag_set;
  logic [NCH-1:0] flag_nxt;
  logic [NCH-1:0] tx_off;         // channels whose transmitter goes off
  logic [NCH-1:0] rx_sq_r;
  logic [NCH-1:0] tx_sq_r;
  logic [NCH-1:0] tx_dis_out_r;
  logic           pres_n_r;
  logic           pres_oe_r;

  // one sequencer per card, each with its own reset and irq
  card_ctl_unit
  #(
    .RST_MIN_CYC (RST_MIN_CYC),
    .INIT_CYC    (INIT_CYC)
  )
  u_lower_card
  (
    .clk_sys_in            (clk_sys_in),
    .clk_en_in             (clk_en_in),
    .nrst_in               (nrst_in),
    .card_reset_n_in       (lower_card_reset_n_in), // RULE16
    .np_read_in            (np_read_in[0]),
    .flag_read_in          (flag_read_in[0]),
    .event_in              (card_evt[0]),
    .card_irq_n_out        (irq_n[0]),
    .card_irq_oe_out       (irq_oe[0]),
    .init_pending_flag_out (pend[0]),
    .in_reset_out          (in_reset[0])
  );

  card_ctl_unit
  #(
    .RST_MIN_CYC (RST_MIN_CYC),
    .INIT_CYC    (INIT_CYC)
  )
  u_upper_card
  (
    .clk_sys_in            (clk_sys_in),
    .clk_en_in             (clk_en_in),
    .nrst_in               (nrst_in),
    .card_reset_n_in       (upper_card_reset_n_in), // RULE16
    .np_read_in            (np_read_in[1]),
    .flag_read_in          (flag_read_in[1]),
    .event_in              (card_evt[1]),
    .card_irq_n_out        (irq_n[1]),
    .card_irq_oe_out       (irq_oe[1]),
    .init_pending_flag_out (pend[1]),
    .in_reset_out          (in_reset[1])
  );

  // detector sync, three stages on every channel
  always_ff @(posedge clk_sys_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      rx_s1_r  <= '0;
      rx_s2_r  <= '0;
      rx_s3_r  <= '0;
      rx_los_r <= '0;
      tx_s1_r  <= '0;
      tx_s2_r  <= '0;
      tx_s3_r  <= '0;
      tx_los_r <= '0;
    end
    else if (clk_en_in)
    begin
      rx_s1_r  <= rx_los_in;
      rx_s2_r  <= rx_s1_r;
      rx_s3_r  <= rx_s2_r;
      rx_los_r <= agree(rx_s2_r, rx_s3_r, rx_los_r);
      tx_s1_r  <= tx_los_in;
      tx_s2_r  <= tx_s1_r;
      tx_s3_r  <= tx_s2_r;
      tx_los_r <= agree(tx_s2_r, tx_s3_r, tx_los_r);
    end
  end

  // squelch disable settings; card reset restores the default
  always_ff @(posedge clk_sys_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      rx_dis_r <= {NCH{card_ctl_pkg::SQ_DIS_RST}};
      tx_dis_r <= {NCH{card_ctl_pkg::SQ_DIS_RST}};
    end
    else if (clk_en_in)
    begin
      for (int c = 0; c < 2; c++)
      begin
        if (in_reset[c])
        begin
          // defaults keep squelch active
          rx_dis_r[c*CH_PER_CARD +: CH_PER_CARD] <= {CH_PER_CARD{card_ctl_pkg::SQ_DIS_RST}}; // RULE1
          tx_dis_r[c*CH_PER_CARD +: CH_PER_CARD] <= {CH_PER_CARD{card_ctl_pkg::SQ_DIS_RST}}; // RULE1
        end
        else if (cfg_we_in[c])
        begin
          rx_dis_r[c*CH_PER_CARD +: CH_PER_CARD] <= cfg_rx_sq_dis_in; // RULE12
          tx_dis_r[c*CH_PER_CARD +: CH_PER_CARD] <= cfg_tx_sq_dis_in; // RULE14
        end
      end
    end
  end

  // input-loss flags: flag read and card reset clear, set wins over both
  always_comb
  begin
    flag_set = tx_los_r & {NCH{TX_SQ_IMPL}}; // RULE13
    flag_nxt = (flag_r & ~per_card(flag_read_in) & ~per_card(in_reset)) | flag_set; // RULE8
    tx_off   = tx_los_r & ~tx_dis_r & {NCH{TX_SQ_IMPL}}; // RULE13
    for (int c = 0; c < 2; c++)
      card_evt[c] = card_fault_in[c] |
                    (|(flag_set[c*CH_PER_CARD +: CH_PER_CARD] &
                       ~flag_r[c*CH_PER_CARD +: CH_PER_CARD])); // RULE7
  end

  // flag register
  always_ff @(posedge clk_sys_in or negedge nrst_in)
  begin
    if (!nrst_in)
      flag_r <= '0;
    else if (clk_en_in)
      flag_r <= flag_nxt;
  end

  // line controls; squelch mutes swing, termination left untouched
  always_ff @(posedge clk_sys_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      rx_sq_r      <= '0;
      tx_sq_r      <= '0;
      tx_dis_out_r <= '0;
    end
    else if (clk_en_in)
    begin
      rx_sq_r      <= rx_los_r & ~rx_dis_r; // RULE10 RULE11
      // average-power links get a full disable, amplitude links a squelch
      tx_dis_out_r <= tx_off & {NCH{tx_off_avg_power_in}}; // RULE15
      tx_sq_r      <= tx_off & {NCH{!tx_off_avg_power_in}}; // RULE15
    end
  end

  // presence is driven low from reset onward
  always_ff @(posedge clk_sys_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      pres_n_r  <= card_ctl_pkg::DRIVE_LOW_LVL; // RULE6
      pres_oe_r <= 1'b1; // RULE6
    end
    else if (clk_en_in)
    begin
      pres_n_r  <= card_ctl_pkg::DRIVE_LOW_LVL; // RULE6
      pres_oe_r <= 1'b1; // RULE6
    end
  end

  // outputs, each straight from a flip-flop
  assign lower_card_irq_n_out   = irq_n[0];
  assign lower_card_irq_oe_out  = irq_oe[0];
  assign upper_card_irq_n_out   = irq_n[1];
  assign upper_card_irq_oe_out  = irq_oe[1];
  assign module_present_n_out   = pres_n_r;
  assign module_present_oe_out  = pres_oe_r;
  assign init_pending_flag_out  = pend;
  assign tx_input_loss_flag_out = flag_r;
  assign rx_squelch_out         = rx_sq_r;
  assign tx_squelch_out         = tx_sq_r;
  assign tx_disable_out         = tx_dis_out_r;

  // loss on an enabled receive channel squelches it
  a_rx_squelch_los: assert property (@(posedge clk_sys_in) disable iff (!nrst_in) // RULE10
    clk_en_in && |(rx_los_r & ~rx_dis_r)
    |=> (rx_squelch_out & $past(rx_los_r & ~rx_dis_r)) == $past(rx_los_r & ~rx_dis_r))
    else $error("receive loss not squelched");

  // a receive channel with squelch disabled is never squelched
  a_rx_sq_disabled: assert property (@(posedge clk_sys_in) disable iff (!nrst_in) // RULE12
    clk_en_in |=> (rx_squelch_out & $past(rx_dis_r)) == '0)
    else $error("disabled receive squelch acted");

  // lower card reset returns its squelch disables to default
  a_sq_default: assert property (@(posedge clk_sys_in) disable iff (!nrst_in) // RULE12
    clk_en_in && in_reset[0]
    |=> rx_dis_r[CH_PER_CARD-1:0] == '0 && tx_dis_r[CH_PER_CARD-1:0] == '0)
    else $error("squelch default not restored");

  // transmit loss sets flag and turns channel off
  a_tx_loss_flag: assert property (@(posedge clk_sys_in) disable iff (!nrst_in) // RULE13
    clk_en_in && |tx_off
    |=> (|(flag_r & (tx_squelch_out | tx_disable_out))))
    else $error("transmit loss not handled");

  // disabled channels never go off
  a_tx_sq_off: assert property (@(posedge clk_sys_in) disable iff (!nrst_in) // RULE14
    ((tx_squelch_out | tx_disable_out) & $past(tx_dis_r) & $past({NCH{clk_en_in}})) == '0)
    else $error("disabled transmit squelch acted");

  // squelch and disable exclusive per channel
  a_tx_mode_excl: assert property (@(posedge clk_sys_in) disable iff (!nrst_in) // RULE15
    (tx_squelch_out & tx_disable_out) == '0)
    else $error("transmit squelch and disable together");

  // presence always driven low
  a_present_low: assert property (@(posedge clk_sys_in) disable iff (!nrst_in) // RULE6
    module_present_oe_out && !module_present_n_out)
    else $error("presence not driven low");

  // a new flag is not lost to a read in the same cycle
  a_flag_set_wins: assert property (@(posedge clk_sys_in) disable iff (!nrst_in) // RULE13
    clk_en_in && |(flag_set & per_card(flag_read_in))
    |=> (flag_r & $past(flag_set)) == $past(flag_set))
    else $error("flag lost to read");

  // a flag read clears that card's flags whose loss has gone
  a_flag_read_clear: assert property (@(posedge clk_sys_in) disable iff (!nrst_in) // RULE13
    clk_en_in && |flag_read_in
    |=> (tx_input_loss_flag_out & $past(per_card(flag_read_in) & ~flag_set)) == '0)
    else $error("flag not cleared by read");

endmodule // module_card_reset_irq_squelch

// *** test/host_ctl_model.sv ***
`timescale 1ns/100ps
module host_ctl_model
(
  // open-drain pins from the module
  input  wire logic [1:0] irq_n_in,
  input  wire logic [1:0] irq_oe_in,
  input  wire logic       present_n_in,
  input  wire logic       present_oe_in,
  // line levels on the host board
  output logic [1:0]      irq_wire_out,
  output logic            present_wire_out
);
  // host pull-ups hold each line high unless the module sinks it
  always_comb
  begin
    for (int c = 0; c < 2; c++)
      irq_wire_out[c] = irq_oe_in[c] ? irq_n_in[c] : 1'b1;
    present_wire_out = present_oe_in ? present_n_in : 1'b1;
  end
endmodule // host_ctl_model

// *** test/module_card_reset_irq_squelch_bench.sv ***
`timescale 1ns/100ps
module module_card_reset_irq_squelch_bench;
  localparam int RMIN = 4;  // shortened reset pulse count
  localparam int INIT = 20; // shortened init count
  // stimulus
  logic        clk_sys_in = 1'b0;
  logic        nrst_in    = 1'b0;
  logic        clk_en     = 1'b1;
  logic [1:0]  rst_n      = 2'b11;
  logic [1:0]  np_rd      = 2'b00;
  logic [1:0]  fl_rd      = 2'b00;
  logic [1:0]  fault      = 2'b00;
  logic [1:0]  cfg_we     = 2'b00;
  logic [7:0]  rx_dis     = 8'h00;
  logic [7:0]  tx_dis     = 8'h00;
  logic        avg        = 1'b0;
  logic [15:0] rx_los     = 16'h0000;
  logic [15:0] tx_los     = 16'h0000;
  // observed
  logic [1:0]  irq_n, irq_oe, pend, irq_w;
  logic        prs_n, prs_oe, prs_w;
  logic [15:0] tx_flag, rx_sq, tx_sq, tx_dsb;
  int          err_total   = 0;
  int          checks_done = 0;

  module_card_reset_irq_squelch #(.CH_PER_CARD(8), .TX_SQ_IMPL(1'b1), .RST_MIN_CYC(RMIN),
    .INIT_CYC(INIT)) uut (.clk_sys_in(clk_sys_in), .clk_en_in(clk_en), .nrst_in(nrst_in),
    .lower_card_reset_n_in(rst_n[0]), .upper_card_reset_n_in(rst_n[1]),
    .lower_card_irq_n_out(irq_n[0]), .lower_card_irq_oe_out(irq_oe[0]),
    .upper_card_irq_n_out(irq_n[1]), .upper_card_irq_oe_out(irq_oe[1]),
    .module_present_n_out(prs_n), .module_present_oe_out(prs_oe), .np_read_in(np_rd),
    .flag_read_in(fl_rd), .card_fault_in(fault), .cfg_we_in(cfg_we), .cfg_rx_sq_dis_in(rx_dis),
    .cfg_tx_sq_dis_in(tx_dis), .tx_off_avg_power_in(avg), .init_pending_flag_out(pend),
    .tx_input_loss_flag_out(tx_flag), .rx_los_in(rx_los), .tx_los_in(tx_los),
    .rx_squelch_out(rx_sq), .tx_squelch_out(tx_sq), .tx_disable_out(tx_dsb));

  host_ctl_model host (.irq_n_in(irq_n), .irq_oe_in(irq_oe), .present_n_in(prs_n),
    .present_oe_in(prs_oe), .irq_wire_out(irq_w), .present_wire_out(prs_w));

  // 200 MHz clock
  always #2.5 clk_sys_in = ~clk_sys_in;

  // advance n edges, then step off the edge
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_in);
    #1;
  endtask

  // compare and report
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // counts and verdict
  task automatic complete_run;
    $display("checks=%0d errors=%0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // bounded wait for an irq wire level; a miss ends the run
  task automatic wait_irq(input int c, input logic lvl, input int lim);
    int k;
    k = 0;
    while (irq_w[c] !== lvl && k < lim)
    begin
      tick(1);
      k++;
    end
    check(16'(irq_w[c]), 16'(lvl));
    if (irq_w[c] !== lvl)
      complete_run();
  endtask

  // host status reads, one-cycle pulses
  task automatic host_read(input logic [1:0] np, input logic [1:0] fl);
    np_rd = np;
    fl_rd = fl;
    tick(1);
    np_rd = 2'b00;
    fl_rd = 2'b00;
    tick(1);
  endtask

  // squelch disable write
  task automatic set_cfg(input logic [1:0] we, input logic [7:0] rd, input logic [7:0] td);
    cfg_we = we;
    rx_dis = rd;
    tx_dis = td;
    tick(1);
    cfg_we = 2'b00;
    tick(3);
  endtask

  // main sequence
  initial
  begin
    tick(1);
    check(16'(pend), 16'h3);
    check(16'({prs_w, irq_w}), 16'h3);
    tick(2);
    nrst_in = 1'b1;
    tick(INIT - 4);
    check(16'({pend, irq_w}), 16'hF);
    wait_irq(0, 1'b0, 12);
    wait_irq(1, 1'b0, 2);
    check(16'(pend), 16'h0);
    // status is read only after completion
    host_read(2'b01, 2'b00);
    tick(4);
    check(16'(irq_w), 16'h0);
    host_read(2'b00, 2'b01);
    wait_irq(0, 1'b1, 4);
    host_read(2'b10, 2'b10);
    wait_irq(1, 1'b1, 4);
    // receive squelch on loss of signal, then disabled on lower ch0
    rx_los = 16'h8001;
    tick(10);
    check(rx_sq, 16'h8001);
    set_cfg(2'b01, 8'h01, 8'h00);
    check(rx_sq, 16'h8000);
    // transmit input loss on upper ch8
    tx_los = 16'h0100;
    tick(10);
    check(tx_sq, 16'h0100);
    check(tx_dsb, 16'h0000);
    check(tx_flag, 16'h0100);
    check(16'(irq_w), 16'h1);
    avg = 1'b1;
    tick(3);
    check(tx_dsb | (tx_sq << 1), 16'h0100);
    set_cfg(2'b10, 8'h00, 8'h01);
    check(tx_dsb | tx_sq, 16'h0000);
    check(tx_flag, 16'h0100);
    // flag read while loss persists: flag stays, event irq clears
    host_read(2'b00, 2'b10);
    check(tx_flag, 16'h0100);
    check(16'(irq_w), 16'h3);
    tx_los = 16'h0000;
    tick(8);
    host_read(2'b00, 2'b10);
    wait_irq(1, 1'b1, 4);
    check(tx_flag, 16'h0000);
    // fault on lower card
    fault  = 2'b01;
    clk_en = 1'b0;
    tick(3);
    // frozen block ignores the fault
    check(16'(irq_w), 16'h3);
    clk_en = 1'b1;
    tick(1);
    fault  = 2'b00;
    wait_irq(0, 1'b0, 4);
    host_read(2'b00, 2'b01);
    wait_irq(0, 1'b1, 4);
    // short reset pulse is ignored
    rst_n = 2'b10;
    tick(RMIN - 1);
    rst_n = 2'b11;
    tick(12);
    check(16'(pend), 16'h0);
    // long reset on lower card, held beyond the init time
    rst_n = 2'b10;
    tick(RMIN + 8);
    check(16'({pend, irq_w}), 16'h7);
    tick(INIT + 5);
    check(16'(pend), 16'h1);
    rst_n = 2'b11;
    tick(INIT - 2);
    check(16'({pend, irq_w}), 16'h7);
    wait_irq(0, 1'b0, 14);
    check(16'({pend, irq_w}), 16'h2);
    check(rx_sq, 16'h8001);
    complete_run();
  end
endmodule // module_card_reset_irq_squelch_bench
